// >>> hdl/sfs_regs.svh
// Constants of the sweep frequency sequencer: field positions, reset values, timing counts.
// Assumes a single 20 MHz clock; included by bare name from the design files.
`ifndef SFS_REGS_SVH
`define SFS_REGS_SVH

`define SFS_CLK_PERIOD_NS 50
`define SFS_PHASES 4
`define SFS_PRESCALE 5
`define SFS_PRESCALE_LAST 3'h4
`define SFS_TICK_NS (`SFS_PHASES * `SFS_PRESCALE * `SFS_CLK_PERIOD_NS)
`define SFS_UPDATE_US 10
`define SFS_WINDOW_US 8
`define SFS_WINDOW_TICKS 4'((`SFS_WINDOW_US * 1000) / `SFS_TICK_NS)
`define SFS_BURST_MIN_PPS 2000000
`define SFS_DIGIT_MAX 4'h9
`define SFS_DIV10_LAST 4'h9
`define SFS_MULT_HALF 4'hb
`define SFS_MULT_HALF_LEN 4'h5
`define SFS_MULT_MAX 4'ha
`define SFS_LIMIT_LSB 16
`define SFS_DECADES 8
`define SFS_TOP_RATE_DECADE 3'h1
`define SFS_BASE_DECADE 3'h0
`define SFS_WORD_RST 32'h0000_0000

`endif

// >>> hdl/sfs_pkg.sv
// Types shared by the sweep frequency sequencer modules.
// Assumes nothing of its surroundings.
package sfs_pkg;
    typedef enum logic [3:0] {
        SFS_PH1 = 4'h1,
        SFS_PH2 = 4'h2,
        SFS_PH3 = 4'h4,
        SFS_PH4 = 4'h8
    } sfs_phase_e;
    typedef enum logic [1:0] {
        SFS_SENSE_UP = 2'h0,
        SFS_SENSE_DOWN = 2'h1,
        SFS_SENSE_TRI = 2'h2
    } sfs_sense_e;
    typedef enum logic [1:0] {
        SFS_RATE_10K = 2'h0,
        SFS_RATE_100K = 2'h1,
        SFS_RATE_1M = 2'h2
    } sfs_rate_e;
    typedef logic [31:0] sfs_word_t;
endpackage

// >>> hdl/sfs_burst_if.sv
// Signals between the sweep sequencer core and its burst generator.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface sfs_burst_if;
    logic count_en;
    logic phase3;
    logic window_start;
    logic [3:0] mult;
    logic burst_pulse;
    modport ctrl (output count_en, output phase3, output window_start, output mult,
                  input burst_pulse);
    modport gen (input count_en, input phase3, input window_start, input mult,
                 output burst_pulse);
endinterface
`default_nettype wire

// >>> hdl/sfs_burst_gen.sv
// Burst generator: gates clock phase three pulses into one burst per update window, or one per two windows for the 2.5 multiplier.
// Assumes window_start is a one-cycle pulse already synchronised to i_clock.
`timescale 1ns/1ps
`default_nettype none
`include "sfs_regs.svh"
module sfs_burst_gen (
    input wire logic i_clock,
    input wire logic i_arst_n,
    sfs_burst_if.gen bus
);
    logic [2:0] presc_r;
    logic [3:0] tick_r;
    logic burst_en_r;
    logic [3:0] cnt_r;
    logic stop_d_r;
    logic half_r;
    logic [3:0] target;
    logic gated;
    logic stop_lvl;
    logic stop_rise;
    logic window_open;

    assign target = (bus.mult == `SFS_MULT_HALF) ? `SFS_MULT_HALF_LEN :
                    (bus.mult == 4'h0 || bus.mult > `SFS_MULT_MAX) ? 4'h1 : bus.mult;
    assign gated = burst_en_r & bus.count_en & bus.phase3;
    assign bus.burst_pulse = gated;
    assign stop_lvl = (cnt_r == target);
    assign stop_rise = stop_lvl & ~stop_d_r;
    assign window_open = (tick_r < `SFS_WINDOW_TICKS);

    ////////////////////////////////////////////////////////////////////////////
    // The prescaler divides phase three by five, giving 1 us ticks in the window.
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            presc_r <= 3'h0;
            tick_r <= 4'h0;
        end
        else if (bus.window_start)
        begin
            presc_r <= 3'h0;
            tick_r <= 4'h0;
        end
        else if (bus.phase3)
        begin
            if (presc_r == `SFS_PRESCALE_LAST)
            begin
                presc_r <= 3'h0;
                if (window_open)
                    tick_r <= tick_r + 4'h1;
            end
            else
                presc_r <= presc_r + 3'h1;
        end
    end

    // Alternate windows are skipped for the 2.5 multiplier: five steps per two updates.
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
            half_r <= 1'b0;
        else if (bus.window_start)
            half_r <= (bus.mult == `SFS_MULT_HALF) ? ~half_r : 1'b0;
    end

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
            burst_en_r <= 1'b0;
        else if (bus.window_start)
            burst_en_r <= (bus.mult != `SFS_MULT_HALF) || !half_r;
        else if (stop_rise || !window_open)
            burst_en_r <= 1'b0;
    end

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            cnt_r <= 4'h0;
            stop_d_r <= 1'b0;
        end
        else
        begin
            stop_d_r <= stop_lvl;
            if (bus.window_start)
                cnt_r <= 4'h0;
            else if (gated && !stop_lvl)
                cnt_r <= cnt_r + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_arst_n);

    property p_gate;
        bus.burst_pulse |-> burst_en_r && bus.count_en && bus.phase3 && window_open && !stop_lvl;
    endproperty
    a_gate: assert property (p_gate) else $error("burst pulse outside its gate");

    property p_window_start;
        bus.window_start && bus.mult != `SFS_MULT_HALF |=> burst_en_r && cnt_r == 4'h0
            && presc_r == 3'h0;
    endproperty
    a_window_start: assert property (p_window_start) else $error("window start missed");

    sequence s_last_pulse;
        gated && cnt_r == target - 4'h1;
    endsequence
    property p_count_to_target;
        s_last_pulse ##1 !bus.window_start |-> stop_lvl ##1 !burst_en_r;
    endproperty
    a_count_to_target: assert property (p_count_to_target) else $error("burst too long");

    property p_stop_clears;
        stop_rise && !bus.window_start |=> !burst_en_r;
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("burst stop ignored");

    property p_window_close;
        !window_open && !bus.window_start |=> !burst_en_r;
    endproperty
    a_window_close: assert property (p_window_close) else $error("burst past window");
endmodule
`default_nettype wire

// >>> hdl/sfs_sequencer.sv
// Sweep frequency sequencer: steps an eight-decade BCD frequency word for a remotely
// tuned synthesizer. Assumes switch inputs and the 100 kHz reference come from pins,
// and that the synthesizer latches O_FREQ_WORD on O_UPDATE.
`timescale 1ns/1ps
`default_nettype none
`include "sfs_regs.svh"
module sfs_sequencer (
    input wire logic I_CLOCK,
    input wire logic I_ARST_N,
    input wire logic I_START,
    input wire logic I_STOP,
    input wire logic I_REF_100K,
    input wire logic I_MODE_REPEAT,
    input wire logic [1:0] I_SENSE,
    input wire logic [1:0] I_RATE_SEL,
    input wire logic [3:0] I_RATE_MULT,
    input wire logic [15:0] I_UPPER_LIMIT,
    input wire logic [15:0] I_LOWER_LIMIT,
    output logic [31:0] O_FREQ_WORD,
    output logic O_UPDATE,
    output logic O_SWEEPING,
    output logic O_PRESET,
    output logic O_DIR_UP
);
    ////////////////////////////////////////////////////////////////////////////
    // Every input is a switch or a pin, so the whole set passes two flip-flops.
    localparam int SYNC_W = 44;

    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic start_d_r;
    logic stop_d_r;
    logic ref_d_r;
    logic s_start;
    logic s_stop;
    logic s_ref;
    logic repeat_mode;
    sfs_pkg::sfs_sense_e sense;
    sfs_pkg::sfs_rate_e rate;
    logic [3:0] rate_mult;
    logic [15:0] upper_lim;
    logic [15:0] lower_lim;

    always_ff @(posedge I_CLOCK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            sync1_r <= {I_START, I_STOP, I_REF_100K, I_MODE_REPEAT, I_SENSE, I_RATE_SEL,
                        I_RATE_MULT, I_UPPER_LIMIT, I_LOWER_LIMIT};
            sync2_r <= sync1_r;
        end
    end

    assign s_start = sync2_r[43];
    assign s_stop = sync2_r[42];
    assign s_ref = sync2_r[41];
    assign repeat_mode = sync2_r[40];
    assign sense = sfs_pkg::sfs_sense_e'(sync2_r[39:38]);
    assign rate = sfs_pkg::sfs_rate_e'(sync2_r[37:36]);
    assign rate_mult = sync2_r[35:32];
    assign upper_lim = sync2_r[31:16];
    assign lower_lim = sync2_r[15:0];

    always_ff @(posedge I_CLOCK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            start_d_r <= 1'b0;
            stop_d_r <= 1'b0;
            ref_d_r <= 1'b0;
        end
        else
        begin
            start_d_r <= s_start;
            stop_d_r <= s_stop;
            ref_d_r <= s_ref;
        end
    end

    logic start_pulse;
    logic stop_pulse;
    logic ref_rise;

    assign start_pulse = s_start & ~start_d_r;
    assign stop_pulse = s_stop & ~stop_d_r;
    assign ref_rise = s_ref & ~ref_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // Four clock phases of one cycle each; phase three doubles as the burst clock,
    // giving 5 Mpps, which keeps a ten-step burst well inside the window.
    sfs_pkg::sfs_phase_e phase_r;
    sfs_pkg::sfs_phase_e phase_nxt;
    logic phase3;
    logic phase4;

    always_comb
    begin
        case (phase_r)
            sfs_pkg::SFS_PH1: phase_nxt = sfs_pkg::SFS_PH2;
            sfs_pkg::SFS_PH2: phase_nxt = sfs_pkg::SFS_PH3;
            sfs_pkg::SFS_PH3: phase_nxt = sfs_pkg::SFS_PH4;
            sfs_pkg::SFS_PH4: phase_nxt = sfs_pkg::SFS_PH1;
            default: phase_nxt = sfs_pkg::SFS_PH1;
        endcase
    end

    always_ff @(posedge I_CLOCK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            phase_r <= sfs_pkg::SFS_PH1;
        else
            phase_r <= phase_nxt;
    end

    assign phase3 = (phase_r == sfs_pkg::SFS_PH3);
    assign phase4 = (phase_r == sfs_pkg::SFS_PH4);

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic at_limit(input sfs_pkg::sfs_word_t w, input logic [15:0] lim);
        return (w[`SFS_LIMIT_LSB-1:0] == 16'h0000) && (w[31:`SFS_LIMIT_LSB] == lim);
    endfunction

    // Ripple a single count through the decades from the given entry decade.
    function automatic sfs_pkg::sfs_word_t step_chain(input sfs_pkg::sfs_word_t w,
                                                      input logic [2:0] first,
                                                      input logic up);
        sfs_pkg::sfs_word_t r;
        logic carry;
        logic [3:0] d;
        r = w;
        carry = 1'b1;
        for (int i = 0; i < `SFS_DECADES; i++)
        begin
            d = w[i*4 +: 4];
            if (carry && i >= int'(first))
            begin
                if (up)
                begin
                    carry = (d == `SFS_DIGIT_MAX);
                    d = carry ? 4'h0 : d + 4'h1;
                end
                else
                begin
                    carry = (d == 4'h0);
                    d = carry ? `SFS_DIGIT_MAX : d - 4'h1;
                end
                r[i*4 +: 4] = d;
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    sfs_pkg::sfs_word_t counter_r;
    logic preset_r;
    logic cen_r;
    logic up_r;
    logic [3:0] div10_r;
    logic tri_sense;
    logic count_enable;
    logic load;
    logic at_upper;
    logic at_lower;
    logic at_end;
    logic end_level;
    logic burst_pulse;
    logic step_pulse;
    logic [2:0] first_decade;
    sfs_pkg::sfs_word_t load_word;

    assign tri_sense = (sense == sfs_pkg::SFS_SENSE_TRI);
    assign count_enable = cen_r & ~preset_r;
    assign load = preset_r & phase3;
    assign at_upper = at_limit(counter_r, upper_lim);
    assign at_lower = at_limit(counter_r, lower_lim);
    assign at_end = up_r ? at_upper : at_lower;
    assign end_level = count_enable & ~tri_sense & at_end;
    // A downward sweep starts from the upper limit and ends at the lower one.
    assign load_word = (sense == sfs_pkg::SFS_SENSE_DOWN) ?
                       {upper_lim, 16'h0000} : {lower_lim, 16'h0000};

    // Start wins over every clear; preset drops only after its load, so no load is skipped.
    always_ff @(posedge I_CLOCK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            preset_r <= 1'b0;
        else if (start_pulse || end_level)
            preset_r <= 1'b1;
        else if (load)
            preset_r <= 1'b0;
    end

    always_ff @(posedge I_CLOCK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            cen_r <= 1'b0;
        else if (start_pulse)
            cen_r <= 1'b1;
        else if (stop_pulse)
            cen_r <= 1'b0;
        else if (end_level && !repeat_mode)
            cen_r <= 1'b0;
    end

    always_ff @(posedge I_CLOCK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            up_r <= 1'b1;
        else if (start_pulse || sense != sfs_pkg::SFS_SENSE_TRI)
            up_r <= (sense != sfs_pkg::SFS_SENSE_DOWN);
        else if (count_enable && at_end)
            up_r <= ~up_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // The lowest rate enters the units decade through an extra divide by ten.
    always_ff @(posedge I_CLOCK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            div10_r <= 4'h0;
        else if (load)
            div10_r <= 4'h0;
        else if (burst_pulse && rate == sfs_pkg::SFS_RATE_10K)
            div10_r <= (div10_r == `SFS_DIV10_LAST) ? 4'h0 : div10_r + 4'h1;
    end

    assign step_pulse = burst_pulse &
                        ((rate != sfs_pkg::SFS_RATE_10K) || (div10_r == `SFS_DIV10_LAST));
    assign first_decade = (rate == sfs_pkg::SFS_RATE_1M) ?
                          `SFS_TOP_RATE_DECADE : `SFS_BASE_DECADE;

    // No step is taken on the end limit of the current direction, so the word never runs past it while the end
    // is being handled.
    always_ff @(posedge I_CLOCK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            counter_r <= `SFS_WORD_RST;
        else if (load)
            counter_r <= load_word;
        else if (count_enable && step_pulse && !at_end)
            counter_r <= step_chain(counter_r, first_decade, up_r);
    end

    ////////////////////////////////////////////////////////////////////////////
    // The word is handed over at each rising reference edge, once per 10 us interval.
    always_ff @(posedge I_CLOCK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            O_FREQ_WORD <= `SFS_WORD_RST;
            O_UPDATE <= 1'b0;
        end
        else
        begin
            O_UPDATE <= ref_rise;
            if (ref_rise)
                O_FREQ_WORD <= counter_r;
        end
    end

    assign O_SWEEPING = cen_r;
    assign O_PRESET = preset_r;
    assign O_DIR_UP = up_r;

    sfs_burst_if burst_bus ();

    assign burst_bus.count_en = count_enable;
    assign burst_bus.phase3 = phase3;
    assign burst_bus.window_start = ref_rise;
    assign burst_bus.mult = rate_mult;
    assign burst_pulse = burst_bus.burst_pulse;

    sfs_burst_gen u_burst (
        .i_clock(I_CLOCK),
        .i_arst_n(I_ARST_N),
        .bus(burst_bus)
    );

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_ARST_N);

    property p_start_sets;
        start_pulse |=> preset_r && cen_r;
    endproperty
    a_start_sets: assert property (p_start_sets) else $error("start did not arm");

    sequence s_load_done;
        load ##1 (counter_r == $past(load_word));
    endsequence
    property p_start_load;
        start_pulse |-> ##[1:4] s_load_done;
    endproperty
    a_start_load: assert property (p_start_load) else $error("limit not loaded");

    property p_preset_clear;
        load && !start_pulse && !end_level |=> !preset_r && phase4;
    endproperty
    a_preset_clear: assert property (p_preset_clear) else $error("preset stuck");

    property p_step_gate;
        counter_r != $past(counter_r) |-> $past(load) || $past(count_enable);
    endproperty
    a_step_gate: assert property (p_step_gate) else $error("count while disabled");

    property p_repeat;
        end_level && repeat_mode && !stop_pulse |=> preset_r && cen_r ##[0:3] load;
    endproperty
    a_repeat: assert property (p_repeat) else $error("repeat reload missed");

    property p_single;
        end_level && !repeat_mode && !start_pulse |=> preset_r && !cen_r;
    endproperty
    a_single: assert property (p_single) else $error("single sweep did not halt");

    property p_stop;
        stop_pulse && !start_pulse && !preset_r |=> !cen_r ##1 $stable(counter_r);
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not hold count");

    property p_update;
        ref_rise |=> O_UPDATE && O_FREQ_WORD == $past(counter_r);
    endproperty
    a_update: assert property (p_update) else $error("word not presented");

    property p_tri_turn;
        tri_sense && !start_pulse && count_enable && up_r && at_upper |=> !up_r && !preset_r;
    endproperty
    a_tri_turn: assert property (p_tri_turn) else $error("triangle did not turn");

    property p_upper_detect;
        count_enable && !tri_sense && up_r && at_upper |=> preset_r;
    endproperty
    a_upper_detect: assert property (p_upper_detect) else $error("upper limit missed");

    property p_top_rate_decade;
        count_enable && step_pulse && !at_end && !load && rate == sfs_pkg::SFS_RATE_1M
            |=> counter_r[3:0] == $past(counter_r[3:0]);
    endproperty
    a_top_rate_decade: assert property (p_top_rate_decade) else $error("wrong decade");
endmodule
`default_nettype wire

// >>> verif/sfs_synth_model.sv
// Synthesizer stand-in: 100 kHz reference square wave and tuning word latch.
// Assumes the 20 MHz bench clock; the word is taken only on the update pulse.
`timescale 1ns/1ps
`default_nettype none
module sfs_synth_model (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic [31:0] i_word,
    input wire logic i_update,
    output logic o_ref,
    output logic [31:0] o_tuned
);
    logic [7:0] div_r;
    ////////////////////////////////////////////////////////////////////////////
    // Reference of 200 cycles, half high, so every update slot is 10 us.
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            div_r <= 8'h00;
            o_ref <= 1'b0;
        end
        else
        begin
            div_r <= (div_r == 8'hc7) ? 8'h00 : div_r + 8'h01;
            o_ref <= (div_r < 8'h64);
        end
    end
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_tuned <= 32'h0000_0000;
        else if (i_update)
            o_tuned <= i_word;
    end
endmodule
`default_nettype wire

// >>> verif/test_sfs_sequencer.sv
// Self-checking bench of the sweep sequencer with a synthesizer model.
// Assumes the design and model sources are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_sfs_sequencer;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic start = 1'b0;
    logic stop = 1'b0;
    logic rep = 1'b0;
    logic [1:0] sense = 2'h0;
    logic [1:0] rate = 2'h2;
    logic [3:0] mult = 4'h1;
    logic [15:0] upper = 16'h2000;
    logic [15:0] lower = 16'h1000;
    logic ref_100k;
    logic [31:0] word;
    logic [31:0] tuned;
    logic upd;
    logic swp;
    logic pre;
    logic dir_up;
    int mismatches = 0;
    int n_compared = 0;
    int gap;
    sfs_sequencer sfs_sequencer_i (.I_CLOCK(clk), .I_ARST_N(arst_n), .I_START(start),
        .I_STOP(stop), .I_REF_100K(ref_100k), .I_MODE_REPEAT(rep), .I_SENSE(sense),
        .I_RATE_SEL(rate), .I_RATE_MULT(mult), .I_UPPER_LIMIT(upper),
        .I_LOWER_LIMIT(lower), .O_FREQ_WORD(word), .O_UPDATE(upd), .O_SWEEPING(swp),
        .O_PRESET(pre), .O_DIR_UP(dir_up));
    sfs_synth_model sfs_synth_model_i (.i_clock(clk), .i_arst_n(arst_n), .i_word(word),
        .i_update(upd), .o_ref(ref_100k), .o_tuned(tuned));
    initial
    begin
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Adds n units at BCD digit d with carry, as the decade chain would.
    function automatic logic [31:0] bcd_step(input logic [31:0] w, input int d, input int n);
        int p;
        for (int s = 0; s < n; s++)
        begin
            p = d;
            w[4*p +: 4] = w[4*p +: 4] + 4'h1;
            while (w[4*p +: 4] == 4'ha && p < 7)
            begin
                w[4*p +: 4] = 4'h0;
                p++;
                w[4*p +: 4] = w[4*p +: 4] + 4'h1;
            end
        end
        return w;
    endfunction
    task automatic wait_update();
        gap = 0;
        do
        begin
            @(negedge clk);
            gap++;
        end
        while (upd !== 1'b1 && gap < 400);
    endtask
    task automatic wait_level(input logic use_dir, input logic lvl);
        int n;
        n = 0;
        while ((use_dir ? dir_up : pre) !== lvl && n < 25000)
        begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic press(input logic is_stop);
        @(posedge clk);
        start <= !is_stop;
        stop <= is_stop;
        repeat (3) @(posedge clk);
        @(negedge clk);
        if (!is_stop)
            check(32'({pre, swp}), 32'h3);
        @(posedge clk);
        start <= 1'b0;
        stop <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Two full windows per entry, so the 2.5 setting and the divide by ten even out.
    task automatic rates();
        logic [31:0] w1;
        logic [1:0] tr [6] = '{2'h2, 2'h1, 2'h0, 2'h2, 2'h1, 2'h2};
        logic [3:0] tm [6] = '{4'h3, 4'ha, 4'ha, 4'hb, 4'h1, 4'h3};
        int td [6] = '{1, 0, 0, 1, 0, 1};
        int ts [6] = '{6, 20, 2, 5, 2, 6};
        for (int k = 0; k < 6; k++)
        begin
            @(posedge clk);
            rate <= tr[k];
            mult <= tm[k];
            sense <= (k == 5) ? 2'h1 : 2'h0;
            press(1'b0);
            wait_update();
            wait_update();
            w1 = word;
            wait_update();
            check(32'(gap), 32'd200);
            wait_update();
            if (k == 5)
                check(bcd_step(word, td[k], ts[k]), w1);
            else
                check(word, bcd_step(w1, td[k], ts[k]));
            check(32'(dir_up), (k == 5) ? 32'h0 : 32'h1);
            press(1'b1);
            check(32'(swp), 32'h0);
            wait_update();
            w1 = word;
            wait_update();
            check(word, w1);
            check(tuned, w1);
        end
    endtask
    task automatic ends(input logic mode);
        @(posedge clk);
        rep <= mode;
        sense <= 2'h0;
        rate <= 2'h2;
        mult <= 4'ha;
        upper <= 16'h1001;
        press(1'b0);
        wait_level(1'b0, 1'b1);
        check(32'(pre), 32'h1);
        wait_update();
        check(32'(swp), 32'(mode));
        check({word[31:16], 16'h0}, {lower, 16'h0});
        if (!mode)
            check(word, {lower, 16'h0});
        press(1'b1);
    endtask
    task automatic triangle();
        @(posedge clk);
        sense <= 2'h2;
        press(1'b0);
        wait_level(1'b1, 1'b0);
        check(32'({dir_up, pre, swp}), 32'h1);
        press(1'b1);
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        rates();
        ends(1'b1);
        ends(1'b0);
        triangle();
        results();
    end
    initial
    begin
        repeat (80000) @(posedge clk);
        mismatches++;
        results();
    end
endmodule
`default_nettype wire
